// *** src/cvsd_bit_logic.sv ***
`timescale 1ns/1ps

// What this block does
// [R01] coincidence low when history all equal
// [R02] history advances only on bit clock fall
// [R03] encode select high loads comparator decision
// [R04] encode select low loads serial data input
// [R05] serial output updates on bit clock fall
// [R06] encode: output low when signal above feedback
// [R07] decode: output is inverse of data
// [R08] integrator charges on one, else discharges
// [R09] output looped to input toggles every clock
// [R10] one bit per bit clock cycle
// [R11] controller forces patterns via select low, data
// [R12] idle encoder gives alternating one-zero stream
// [R13] new bit enters stage one, oldest dropped
module cvsd_bit_logic (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic bit_clk_i,
    input wire logic encode_sel_i,
    input wire logic comp_above_i,
    input wire logic data_i,
    output logic serial_o,
    output logic integrating_current_o,
    input wire logic coin_pin_i,
    output logic coin_out_o,
    output logic coin_oe_o,
    output logic coin_seen_o,
    output logic [cvsd_pkg::HIST_LEN-1:0] history_o,
    output logic bit_valid_o,
    input wire logic bit_ready_i,
    output logic [cvsd_pkg::FIFO_WIDTH-1:0] bit_word_o,
    output logic overrun_o
);

    typedef struct packed {
        logic bclk_m;
        logic bclk_s;
        logic sel_m;
        logic sel_s;
        logic comp_m;
        logic comp_s;
        logic data_m;
        logic data_s;
        logic pin_m;
        logic pin_s;
        cvsd_pkg::cvsd_edge_st_t edge_st;
        logic [cvsd_pkg::WIDTH_CNT-1:0] cnt;
        logic [cvsd_pkg::HIST_LEN-1:0] hist;
        logic serial;
        logic polarity;
        logic coin;
        logic push;
        logic [cvsd_pkg::FIFO_WIDTH-1:0] word;
        logic overrun;
    } cvsd_st_t;

    cvsd_st_t st_q;
    cvsd_st_t st_d;
    logic fifo_ready;
    logic bit_fall;
    logic new_bit;
    logic [cvsd_pkg::HIST_LEN-1:0] hist_next;
    logic coin_next;

    localparam logic [cvsd_pkg::WIDTH_CNT-1:0] HIGH_MIN =
        cvsd_pkg::WIDTH_CNT'(cvsd_pkg::BCLK_HIGH_MIN_CYC);
    localparam logic [cvsd_pkg::WIDTH_CNT-1:0] LOW_MIN =
        cvsd_pkg::WIDTH_CNT'(cvsd_pkg::BCLK_LOW_MIN_CYC);
    localparam logic [cvsd_pkg::WIDTH_CNT-1:0] CNT_MAX = '1;

    // start values: history, serial and polarity from the package, all else idle
    localparam cvsd_st_t ST_RST = '{
        bclk_m: 1'b0,
        bclk_s: 1'b0,
        sel_m: 1'b0,
        sel_s: 1'b0,
        comp_m: 1'b0,
        comp_s: 1'b0,
        data_m: 1'b0,
        data_s: 1'b0,
        pin_m: 1'b0,
        pin_s: 1'b0,
        edge_st: cvsd_pkg::CVSD_WAIT_LOW,
        cnt: '0,
        hist: cvsd_pkg::HIST_RST,
        serial: cvsd_pkg::SERIAL_RST,
        polarity: cvsd_pkg::POLARITY_RST,
        coin: 1'b0,
        push: 1'b0,
        word: '0,
        overrun: 1'b0
    };

    function automatic logic cvsd_all_same(
        input logic [cvsd_pkg::HIST_LEN-1:0] h
    );
        logic ones;
        logic zeros;
        ones = &h;
        zeros = ~|h;
        cvsd_all_same = ones || zeros;
    endfunction : cvsd_all_same

    // newest bit enters stage one, the oldest stage falls out
    function automatic logic [cvsd_pkg::HIST_LEN-1:0] cvsd_shift(
        input logic [cvsd_pkg::HIST_LEN-1:0] h,
        input logic b
    );
        cvsd_shift = {h[cvsd_pkg::HIST_LEN-2:0], b};
    endfunction : cvsd_shift

    function automatic logic [cvsd_pkg::FIFO_WIDTH-1:0] cvsd_pack_word(
        input logic coin,
        input logic mode,
        input logic bit_val
    );
        cvsd_pack_word = '0;
        cvsd_pack_word[cvsd_pkg::WORD_BIT] = bit_val;
        cvsd_pack_word[cvsd_pkg::WORD_MODE] = mode;
        cvsd_pack_word[cvsd_pkg::WORD_COIN] = coin;
    endfunction : cvsd_pack_word

    // the selected bit is the sense "signal above feedback" or the data level
    assign new_bit = st_q.sel_s ? st_q.comp_s : st_q.data_s; // [R03] [R04] [R11]
    assign hist_next = cvsd_shift(st_q.hist, new_bit); // [R13]
    assign coin_next = cvsd_all_same(hist_next); // [R01]

    always_comb begin
        st_d = st_q;
        bit_fall = 1'b0;
        st_d.push = 1'b0;
        // each sampled pin (bit clock, select, comparator, data, coincidence) passes two flops before anything reads it
        st_d.bclk_m = bit_clk_i;
        st_d.bclk_s = st_q.bclk_m;
        st_d.sel_m = encode_sel_i;
        st_d.sel_s = st_q.sel_m;
        st_d.comp_m = comp_above_i;
        st_d.comp_s = st_q.comp_m;
        st_d.data_m = data_i;
        st_d.data_s = st_q.data_m;
        st_d.pin_m = coin_pin_i;
        st_d.pin_s = st_q.pin_m;
        // saturate so a long idle phase still counts as wide enough
        if (st_q.cnt != CNT_MAX) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        // a bit clock phase shorter than its minimum width is a glitch and is ignored
        case (st_q.edge_st)
            cvsd_pkg::CVSD_WAIT_HIGH: begin
                if (!st_q.bclk_s) begin
                    st_d.cnt = '0;
                    if (st_q.cnt >= HIGH_MIN) begin
                        st_d.edge_st = cvsd_pkg::CVSD_WAIT_LOW;
                        bit_fall = 1'b1; // [R02] [R10]
                    end
                end
            end
            cvsd_pkg::CVSD_WAIT_LOW: begin
                if (st_q.bclk_s) begin
                    st_d.cnt = '0;
                    if (st_q.cnt >= LOW_MIN) begin
                        st_d.edge_st = cvsd_pkg::CVSD_WAIT_HIGH;
                    end
                end
            end
            default: begin
                st_d.edge_st = cvsd_pkg::CVSD_WAIT_LOW;
                st_d.cnt = '0;
            end
        endcase
        if (bit_fall) begin
            st_d.hist = hist_next; // [R13] [R02]
            // output is the inverted decision in both modes
            st_d.serial = !new_bit; // [R05] [R06] [R07] [R09] [R12]
            st_d.polarity = new_bit; // [R08]
            st_d.coin = coin_next; // [R01]
            st_d.word = cvsd_pack_word(coin_next, st_q.sel_s, new_bit);
            st_d.push = 1'b1;
        end
        // judged when the fifo sees the word, so a pop just before still saves it
        if (st_q.push && !fifo_ready) begin
            st_d.overrun = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_RST;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // a word pushed while full is lost; the sticky overrun flag records it
    cvsd_fifo #(
        .WIDTH(cvsd_pkg::FIFO_WIDTH),
        .DEPTH(cvsd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(st_q.push),
        .in_ready_o(fifo_ready),
        .in_data_i(st_q.word),
        .out_valid_o(bit_valid_o),
        .out_ready_i(bit_ready_i),
        .out_data_o(bit_word_o)
    );

    assign serial_o = st_q.serial;
    assign integrating_current_o = st_q.polarity;
    assign history_o = st_q.hist;
    // open-drain: drive low only while coincident
    assign coin_out_o = 1'b0; // [R01]
    assign coin_oe_o = st_q.coin; // [R01]
    // read-back of the shared line, after two flops
    assign coin_seen_o = st_q.pin_s;
    assign overrun_o = st_q.overrun;

endmodule : cvsd_bit_logic

// *** common/cvsd_pkg.sv ***
package cvsd_pkg;

    // system clock
    localparam int CLK_PERIOD_PS = 5000;

    // bit clock pulse widths, in ns
    localparam int BCLK_HIGH_MIN_NS = 300;
    localparam int BCLK_LOW_MIN_NS = 900;

    // least times round up to whole cycles
    localparam int BCLK_HIGH_MIN_CYC =
        (BCLK_HIGH_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BCLK_LOW_MIN_CYC = (BCLK_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int WIDTH_CNT = 8;

    // bit history
    localparam int HIST_LEN = 3;
    localparam logic [HIST_LEN-1:0] HIST_RST = 3'h2;
    localparam logic SERIAL_RST = 1'h1;
    localparam logic POLARITY_RST = 1'h0;

    // stream fifo word: {coincidence, encode_mode, bit}
    localparam int FIFO_WIDTH = 3;
    localparam int FIFO_DEPTH = 32;
    localparam int WORD_BIT = 0;
    localparam int WORD_MODE = 1;
    localparam int WORD_COIN = 2;

    // bit clock edge qualifier states
    typedef enum logic [1:0] {
        CVSD_WAIT_LOW = 2'b01,
        CVSD_WAIT_HIGH = 2'b10
    } cvsd_edge_st_t;

endpackage : cvsd_pkg

// *** src/cvsd_fifo.sv ***
`timescale 1ns/1ps

module cvsd_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } cvsd_fifo_st_t;

    cvsd_fifo_st_t st_q;
    cvsd_fifo_st_t st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    logic full;
    logic empty;

    assign full = (st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
    assign empty = (st_q.wr == st_q.rd);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[st_q.rd[AW-1:0]];
    assign push = ce_i && in_valid_i && !full;
    assign pop = ce_i && out_ready_i && !empty;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st_q.wr[AW-1:0]] <= in_data_i;
        end
    end

endmodule : cvsd_fifo

// *** verification/cvsd_bit_logic_asserts.sv ***
`timescale 1ns/1ps

module cvsd_bit_logic_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_clk_i,
    input wire logic serial_o,
    input wire logic integrating_current_o,
    input wire logic coin_out_o,
    input wire logic coin_oe_o,
    input wire logic coin_seen_o,
    input wire logic [cvsd_pkg::HIST_LEN-1:0] history_o,
    input wire logic bit_valid_o,
    input wire logic overrun_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence hist_step;
        $changed(history_o);
    endsequence
    sequence oe_held;
        coin_oe_o [*5];
    endsequence
    a_coin_match: assert property (coin_oe_o == (history_o == 3'h0 || history_o == 3'h7))
        else $error("coincidence flag disagrees with history");
    a_pin_seen: assert property (oe_held |-> !coin_seen_o)
        else $error("pulled coincidence line not seen");
    a_drain_low: assert property (coin_out_o == 1'b0)
        else $error("open drain data not low");
    a_fall_only: assert property (hist_step |-> !$past(bit_clk_i))
        else $error("history moved without bit clock fall");
    a_shift_in: assert property (hist_step |->
        history_o[2] == $past(history_o[1]) && history_o[1] == $past(history_o[0]))
        else $error("history did not shift");
    a_serial_inv: assert property (serial_o != history_o[0])
        else $error("serial output not inverse of bit");
    a_polarity_bit: assert property (integrating_current_o == history_o[0])
        else $error("integrator polarity wrong");
    a_bit_pushed: assert property (hist_step |-> ##[1:3] bit_valid_o)
        else $error("bit not queued");
    a_overrun_sticky: assert property (overrun_o |=> overrun_o)
        else $error("overrun flag dropped");
endmodule : cvsd_bit_logic_asserts

// *** verification/cvsd_link_model.sv ***
`timescale 1ns/1ps

module cvsd_link_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic loop_i,
    input wire logic tx_i,
    input wire logic serial_i,
    output logic bit_clk_o,
    output logic data_o
);
    // bit clock idles low between runs; data is stale-inverted once its hold time is over
    initial begin
        bit_clk_o = 1'b0;
        data_o = 1'b0;
        forever begin
            @(negedge clk_i);
            if (run_i) begin
                repeat (120) @(negedge clk_i);
                data_o = ~data_o;
                repeat (80) @(negedge clk_i);
                data_o = loop_i ? serial_i : tx_i;
                bit_clk_o = 1'b1;
                repeat (80) @(negedge clk_i);
                bit_clk_o = 1'b0;
            end
        end
    end
endmodule : cvsd_link_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, enc = 1'b0, comp = 1'b0, tx = 1'b0;
    logic run = 1'b0, loop = 1'b0, rdy = 1'b0, s, bclk, din, pin, ser, pol, oe, co, seen, vld, ovr;
    logic [2:0] hist = 3'h2, hst, word;
    // {select, comparator, data, serial, polarity}
    logic [4:0] rows [8] = '{5'h19, 5'h05, 5'h1d, 5'h16, 5'h0a, 5'h02, 5'h0d, 5'h12};
    // {coincidence, mode, bit} of each bit that fits in the fifo
    logic [2:0] exp_word [32];
    int fail_count = 0, check_count = 0, cycles = 0, n = 0;
    assign pin = oe ? co : 1'b1;
    cvsd_bit_logic cvsd_bit_logic_i (.clk_i, .rst_i, .ce_i, .bit_clk_i(bclk), .encode_sel_i(enc),
        .comp_above_i(comp), .data_i(din), .serial_o(ser), .integrating_current_o(pol),
        .coin_pin_i(pin), .coin_out_o(co), .coin_oe_o(oe), .coin_seen_o(seen), .history_o(hst),
        .bit_valid_o(vld), .bit_ready_i(rdy), .bit_word_o(word), .overrun_o(ovr));
    cvsd_link_model cvsd_link_model_i (.clk_i, .run_i(run), .loop_i(loop), .tx_i(tx),
        .serial_i(ser), .bit_clk_o(bclk), .data_o(din));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic check(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) fail_count++;
    endtask : check
    task automatic next_bit;
        @(negedge bclk);
        repeat (6) @(negedge clk_i);
    endtask : next_bit
    task automatic report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 15000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        run = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {enc, comp, tx} = rows[i][4:2];
            hist = {hist[1:0], rows[i][0]};
            exp_word[i] = {hist == 3'h0 || hist == 3'h7, rows[i][4], rows[i][0]};
            next_bit();
            check({1'b0, ser, pol}, {1'b0, rows[i][1:0]});
            check({2'h0, oe}, {2'h0, hist == 3'h0 || hist == 3'h7});
            check(hst, hist);
        end
        loop = 1'b1;
        // first half loops the output back, second half idles the encoder loop
        for (int i = 0; i < 26; i++) begin
            enc = (i >= 13);
            comp = ser;
            s = ~hist[0];
            hist = {hist[1:0], s};
            if (i < 24) exp_word[8 + i] = {hist == 3'h0 || hist == 3'h7, enc, s};
            next_bit();
            check({1'b0, ser, pol}, {1'b0, ~s, s});
            check(hst, hist);
        end
        check({2'h0, ovr}, 3'h1);
        run = 1'b0;
        rdy = 1'b1;
        ce_i = 1'b0;
        repeat (5) @(negedge clk_i);
        check(word, exp_word[0]);
        check({1'b0, ovr, vld}, 3'h3);
        ce_i = 1'b1;
        repeat (40) begin
            if (vld) check(word, exp_word[n]);
            n += vld;
            @(negedge clk_i);
        end
        check({1'b0, n == 32, vld}, 3'h2);
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check({ser, pol, oe}, 3'h4);
        check(hst, 3'h2);
        check({1'b0, ovr, vld}, 3'h0);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check({ser, pol, oe}, 3'h4);
        check(hst, 3'h2);
        report_and_stop();
    end
endmodule : testbench

bind cvsd_bit_logic cvsd_bit_logic_asserts cvsd_bit_logic_asserts_i (.clk_i, .rst_i, .bit_clk_i,
    .serial_o, .integrating_current_o, .coin_out_o, .coin_oe_o, .coin_seen_o, .history_o,
    .bit_valid_o, .overrun_o);
